// ===== ddr_rd_pkg.sv
/*
  Shared constants for the read-burst link: command codes, mode field
  layout, reset values and timing figures.
  Assumes both ends and the link interface import it.
*/
package ddr_rd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BA_W   = 3;
  localparam int NBANK  = 8;
  localparam int ADDR_W = 14;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 8;
  localparam int LAT_W  = 3;
  localparam int CNT_W  = 5;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_ACT   = 3'h1,
    CMD_READ  = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRE   = 3'h4,
    CMD_MODE  = 3'h5
  } cmd_t;

  typedef logic [DQ_W-1:0] elem_t;

  // ----------------------------------------------------------------
  // Address field layout
  // ----------------------------------------------------------------
  localparam int AP_BIT       = 10;
  localparam int MODE_CL_LSB  = 0;
  localparam int MODE_AL_LSB  = 3;
  localparam int MODE_BL8_BIT = 6;

  localparam logic [LAT_W-1:0] CL_RST  = 3'h3;
  localparam logic [LAT_W-1:0] AL_RST  = 3'h0;
  localparam logic             BL8_RST = 1'b0;

  // Strobe halves: {first half, second half}
  localparam logic [1:0] DQS_PRE  = 2'h0;
  localparam logic [1:0] DQS_DATA = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CK_DIV        = 2;
  localparam int CK_PERIOD_NS  = CLK_PERIOD_NS * CK_DIV;
  localparam int T_RTP_NS_DEF  = 8;
  localparam int T_RP_NS_DEF   = 15;
  localparam int RTP_MIN_CK    = 2;
  localparam int WR_EXTRA_CK   = 2;
  localparam int TRUNC_GAP_CK  = 2;
  localparam int SLOT_DEPTH    = 18;
  localparam int SLOT_MIN      = 17;

endpackage

// ===== ddr_link_if.sv
/*
  Link between the memory controller end and the memory device end.
  Assumes the controller drives ck; read data is carried as one pair of
  elements per ck cycle, upper half first (rising half).
*/
interface ddr_link_if;
  import ddr_rd_pkg::*;

  logic                ck;
  cmd_t                cmd;
  logic [BA_W-1:0]     ba;
  logic [ADDR_W-1:0]   addr;
  logic [2*DQ_W-1:0]   dq;
  logic                dq_oe;
  logic [1:0]          dqs;
  logic [1:0]          dqs_n;
  logic                dqs_oe;

  modport dev (
    input  ck,
    input  cmd,
    input  ba,
    input  addr,
    output dq,
    output dq_oe,
    output dqs,
    output dqs_n,
    output dqs_oe
  );

  modport ctl (
    output ck,
    output cmd,
    output ba,
    output addr,
    input  dq,
    input  dq_oe,
    input  dqs,
    input  dqs_n,
    input  dqs_oe
  );

endinterface

// ===== ddr_rd_device.sv
/*
  Memory device end: decodes commands on ck, schedules read bursts and
  drives data and strobe pairs, tracks open rows and auto precharge.
  Assumes the controller keeps the spacing rules; read data is a fixed
  pattern of column and bank, there is no storage array.
*/
module ddr_rd_device #(
  parameter int DEPTH = ddr_rd_pkg::SLOT_DEPTH
) (
  ddr_link_if.dev                        link,
  input  wire logic                      resetn_i,
  output logic [ddr_rd_pkg::NBANK-1:0]   bank_open_o
);
  import ddr_rd_pkg::*;

  if (DEPTH < SLOT_MIN)
  begin : g_depth_check
    $error("DEPTH too small for the longest read latency");
  end

  typedef struct packed {
    logic             v;
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
    logic [1:0]       k;
  } slot_t;

  // ----------------------------------------------------------------
  // Mode
  // ----------------------------------------------------------------
  logic [LAT_W-1:0] cl_reg;
  logic [LAT_W-1:0] al_reg;
  logic             bl8_reg;

  always_ff @(posedge link.ck or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cl_reg  <= CL_RST;
      al_reg  <= AL_RST;
      bl8_reg <= BL8_RST;
    end
    else if (link.cmd == CMD_MODE)
    begin
      cl_reg  <= link.addr[MODE_CL_LSB +: LAT_W];
      al_reg  <= link.addr[MODE_AL_LSB +: LAT_W];
      bl8_reg <= link.addr[MODE_BL8_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Burst scheduling
  // ----------------------------------------------------------------
  function automatic logic [COL_W-1:0] elem_col(input logic [COL_W-1:0] base,
                                                input logic [2:0] n,
                                                input logic bl8);
    logic [2:0] off;
    off = base[2:0] + n;
    // Sequential order wraps inside the burst
    elem_col = bl8 ? {base[COL_W-1:3], off} : {base[COL_W-1:2], off[1:0]};
  endfunction

  function automatic elem_t pattern(input logic [BA_W-1:0] ba,
                                    input logic [COL_W-1:0] col);
    pattern = elem_t'({col, ba});
  endfunction

  slot_t slot_reg  [DEPTH];
  slot_t slot_next [DEPTH];
  int    rl;
  int    beats;

  always_comb
  begin
    rl    = int'(al_reg) + int'(cl_reg);
    beats = bl8_reg ? 4 : 2;
    for (int i = 0; i < DEPTH - 1; i++)
      slot_next[i] = slot_reg[i + 1];
    slot_next[DEPTH-1] = '0;
    if (link.cmd == CMD_READ) // [RQ1]
    begin
      // A later read overwrites pending beats, which truncates the old burst
      for (int k = 0; k < 4; k++)
      begin
        if (k < beats && rl - 1 + k >= 0 && rl - 1 + k < DEPTH) // [RQ3] [RQ8]
          slot_next[rl - 1 + k] = '{1'b1, link.ba, link.addr[COL_W-1:0], 2'(k)};
      end
    end
  end

  always_ff @(posedge link.ck or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        slot_reg[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
        slot_reg[i] <= slot_next[i];
    end
  end

  // ----------------------------------------------------------------
  // Data and strobe outputs
  // ----------------------------------------------------------------
  logic [2*DQ_W-1:0] dq_reg;
  logic              dq_oe_reg;
  logic [1:0]        dqs_reg;
  logic              dqs_oe_reg;

  always_ff @(posedge link.ck or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dq_reg     <= '0;
      dq_oe_reg  <= 1'b0;
      dqs_reg    <= DQS_PRE;
      dqs_oe_reg <= 1'b0;
    end
    else
    begin
      dq_reg <= {pattern(slot_reg[0].ba,
                         elem_col(slot_reg[0].col, {slot_reg[0].k, 1'b0}, bl8_reg)),
                 pattern(slot_reg[0].ba,
                         elem_col(slot_reg[0].col, {slot_reg[0].k, 1'b1}, bl8_reg))}; // [RQ4]
      dq_oe_reg  <= slot_reg[0].v; // [RQ7]
      dqs_oe_reg <= slot_reg[0].v | slot_reg[1].v; // [RQ5]
      // Second half low holds the postamble on the last element
      dqs_reg    <= slot_reg[0].v ? DQS_DATA : DQS_PRE; // [RQ5] [RQ6]
    end
  end

  assign link.dq     = dq_reg;
  assign link.dq_oe  = dq_oe_reg;
  assign link.dqs    = dqs_reg;
  assign link.dqs_n  = ~dqs_reg;
  assign link.dqs_oe = dqs_oe_reg;

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NBANK; g++)
  begin : g_bank
    logic             open_reg;
    logic [CNT_W-1:0] ap_cnt_reg;
    logic             hit;

    assign hit = link.ba == BA_W'(g);

    always_ff @(posedge link.ck or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        open_reg   <= 1'b0;
        ap_cnt_reg <= '0;
      end
      else if (hit && link.cmd == CMD_ACT)
        open_reg <= 1'b1;
      else if (link.cmd == CMD_PRE && (hit || link.addr[AP_BIT]))
        open_reg <= 1'b0;
      else if (hit && link.cmd == CMD_READ && link.addr[AP_BIT])
        ap_cnt_reg <= CNT_W'({al_reg}) + (bl8_reg ? CNT_W'(4) : CNT_W'(2)); // [RQ2]
      else if (ap_cnt_reg != '0)
      begin
        ap_cnt_reg <= ap_cnt_reg - 1'b1;
        if (ap_cnt_reg == CNT_W'(1))
          open_reg <= 1'b0; // [RQ2]
      end
    end

    assign bank_open_o[g] = open_reg;
  end

endmodule

// ===== ddr_rd_ctrl.sv
/*
  Memory controller end: makes ck from clk_i, issues commands one per ck
  cycle under the read, truncation, precharge and mode timing, and
  captures read data pairs.
  Assumes the device end samples commands on the rising edge of ck.
*/

// What this block does
// [RQ1] Read carries bank, column and auto-precharge flag
// [RQ2] Device auto-precharges after burst when asked
// [RQ3] First element arrives AL plus CL later
// [RQ4] One element per half clock
// [RQ5] Strobe preamble low before first element
// [RQ6] Strobe low during last element
// [RQ7] Data lines released after burst
// [RQ8] Gapless reads spaced half burst length
// [RQ9] Burst of four never truncated
// [RQ10] Burst of eight truncated only by read
// [RQ11] Truncating read exactly two clocks later
// [RQ12] Only idle cycles during truncation
// [RQ13] Read data drains before write
// [RQ14] Precharge only after non-auto-precharge read
// [RQ15] Read to precharge spacing formula
// [RQ16] Recovery counted from last prefetch edge
// [RQ17] Wait precharge time before next bank command
// [RQ18] Latencies set by mode load first
// [RQ19] Activate row before reading bank
// [RQ20] Nanosecond minima rounded up to clocks
// [RQ21] Track rows and auto precharge per bank
module ddr_rd_ctrl #(
  parameter int T_RTP_NS = ddr_rd_pkg::T_RTP_NS_DEF,
  parameter int T_RP_NS  = ddr_rd_pkg::T_RP_NS_DEF
) (
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  ddr_link_if.ctl                             link,
  input  wire logic                           req_valid_i,
  output logic                                req_ready_o,
  input  wire ddr_rd_pkg::cmd_t               req_cmd_i,
  input  wire logic [ddr_rd_pkg::BA_W-1:0]    req_ba_i,
  input  wire logic [ddr_rd_pkg::ADDR_W-1:0]  req_addr_i,
  input  wire logic                           req_trunc_i,
  output logic                                rd_valid_o,
  output logic [2*ddr_rd_pkg::DQ_W-1:0]       rd_data_o,
  output logic [ddr_rd_pkg::NBANK-1:0]        bank_open_o
);
  import ddr_rd_pkg::*;

  // ----------------------------------------------------------------
  // Timing in ck cycles
  // ----------------------------------------------------------------
  localparam int RTP_CK   = (T_RTP_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS; // [RQ20]
  localparam int RP_RAW   = (T_RP_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS; // [RQ20]
  localparam int RP_CK    = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int RTPRP_CK = (T_RTP_NS + T_RP_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS; // [RQ20]
  localparam int RTP_GAP  = (RTP_CK > RTP_MIN_CK) ? RTP_CK : RTP_MIN_CK;

  if (RTPRP_CK > 20 || RTP_GAP > 20)
  begin : g_timing_check
    $error("Timing figures exceed the bank counters");
  end

  typedef logic [CNT_W-1:0] cnt_t;

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // Commands change as ck falls, so they are settled at its rise
  logic ck_reg;
  logic tick;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ck_reg <= 1'b0;
    else
      ck_reg <= ~ck_reg;
  end

  assign tick    = ck_reg;
  assign link.ck = ck_reg;

  // ----------------------------------------------------------------
  // Mode mirror
  // ----------------------------------------------------------------
  logic [LAT_W-1:0] cl_reg;
  logic [LAT_W-1:0] al_reg;
  logic             bl8_reg;
  logic             accept;
  cnt_t             half;
  cnt_t             rl;

  assign half = bl8_reg ? cnt_t'(4) : cnt_t'(2);
  assign rl   = cnt_t'(al_reg) + cnt_t'(cl_reg);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cl_reg  <= CL_RST;
      al_reg  <= AL_RST;
      bl8_reg <= BL8_RST;
    end
    else if (accept && req_cmd_i == CMD_MODE)
    begin
      cl_reg  <= req_addr_i[MODE_CL_LSB +: LAT_W]; // [RQ18]
      al_reg  <= req_addr_i[MODE_AL_LSB +: LAT_W];
      bl8_reg <= req_addr_i[MODE_BL8_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Last read
  // ----------------------------------------------------------------
  cnt_t since_rd_reg;
  logic last_ap_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      since_rd_reg <= '1;
      last_ap_reg  <= 1'b0;
    end
    else if (accept && req_cmd_i == CMD_READ)
    begin
      // A read two ck cycles later must see 2 here, as the monitor does
      since_rd_reg <= cnt_t'(1);
      last_ap_reg  <= req_addr_i[AP_BIT];
    end
    else if (tick && since_rd_reg != '1)
      since_rd_reg <= since_rd_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  logic [NBANK-1:0] open_v;
  logic [NBANK-1:0] ap_v;
  logic [NBANK-1:0] pre_ok_v;
  logic [NBANK-1:0] rp_ok_v;
  cnt_t             pre_load;
  cnt_t             apc_load;

  // Wait counted from the edge that starts the last prefetch
  assign pre_load = cnt_t'(al_reg) + half - cnt_t'(2) + cnt_t'(RTP_GAP); // [RQ15] [RQ16]
  assign apc_load = cnt_t'(al_reg) + half - cnt_t'(2) + cnt_t'(RTPRP_CK);

  for (genvar g = 0; g < NBANK; g++)
  begin : g_bank
    logic open_reg;
    logic ap_reg;
    cnt_t pre_wait_reg;
    cnt_t rp_wait_reg;
    logic hit;

    assign hit = accept && req_ba_i == BA_W'(g);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        open_reg     <= 1'b0;
        ap_reg       <= 1'b0;
        pre_wait_reg <= '0;
        rp_wait_reg  <= '0;
      end
      else if (tick)
      begin
        if (hit && req_cmd_i == CMD_ACT)
          open_reg <= 1'b1; // [RQ21]
        else if (hit && req_cmd_i == CMD_PRE)
        begin
          open_reg    <= 1'b0;
          rp_wait_reg <= cnt_t'(RP_CK); // [RQ17]
        end
        else if (hit && req_cmd_i == CMD_READ)
        begin
          pre_wait_reg <= pre_load; // [RQ15]
          if (req_addr_i[AP_BIT])
          begin
            ap_reg      <= 1'b1; // [RQ21]
            rp_wait_reg <= apc_load;
          end
        end
        else
        begin
          if (pre_wait_reg != '0)
            pre_wait_reg <= pre_wait_reg - 1'b1;
          if (rp_wait_reg != '0)
            rp_wait_reg <= rp_wait_reg - 1'b1;
          if (ap_reg && rp_wait_reg == cnt_t'(1))
          begin
            open_reg <= 1'b0;
            ap_reg   <= 1'b0;
          end
        end
      end
    end

    assign open_v[g]   = open_reg;
    assign ap_v[g]     = ap_reg;
    assign pre_ok_v[g] = pre_wait_reg == '0;
    assign rp_ok_v[g]  = rp_wait_reg == '0;
  end

  assign bank_open_o = open_v;

  // ----------------------------------------------------------------
  // Command legality
  // ----------------------------------------------------------------
  logic ok;
  logic busy_rd;
  logic trunc_ok;
  logic row_ok;

  // A burst still prefetching (under half ck cycles since its read) blocks all but a read
  assign busy_rd  = since_rd_reg < half; // [RQ10] [RQ12]
  assign trunc_ok = req_trunc_i && bl8_reg && !last_ap_reg
                    && since_rd_reg == cnt_t'(TRUNC_GAP_CK); // [RQ9] [RQ10] [RQ11]
  assign row_ok   = open_v[req_ba_i] && !ap_v[req_ba_i]; // [RQ19] [RQ21]

  always_comb
  begin
    ok = 1'b0;
    case (req_cmd_i)
      CMD_NOP:   ok = 1'b1;
      CMD_ACT:   ok = !open_v[req_ba_i] && rp_ok_v[req_ba_i] && !busy_rd; // [RQ17]
      CMD_READ:  ok = row_ok && (since_rd_reg >= half || trunc_ok); // [RQ8] [RQ1]
      CMD_WRITE: ok = row_ok && since_rd_reg >= half + cnt_t'(WR_EXTRA_CK); // [RQ13]
      CMD_PRE:   ok = row_ok && pre_ok_v[req_ba_i] && !busy_rd; // [RQ14] [RQ12]
      CMD_MODE:  ok = open_v == '0 && rp_ok_v == '1 && since_rd_reg >= rl + half; // [RQ18]
      default:   ok = 1'b0;
    endcase
  end

  assign req_ready_o = tick && ok;
  assign accept      = req_valid_i && req_ready_o;

  // ----------------------------------------------------------------
  // Command launch
  // ----------------------------------------------------------------
  cmd_t              cmd_reg;
  logic [BA_W-1:0]   ba_reg;
  logic [ADDR_W-1:0] addr_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_reg  <= CMD_NOP;
      ba_reg   <= '0;
      addr_reg <= '0;
    end
    else if (tick)
    begin
      cmd_reg <= accept ? req_cmd_i : CMD_NOP; // [RQ1]
      if (accept)
      begin
        ba_reg   <= req_ba_i;
        addr_reg <= req_addr_i;
      end
    end
  end

  assign link.cmd  = cmd_reg;
  assign link.ba   = ba_reg;
  assign link.addr = addr_reg;

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Sampled half a ck after the device launches; ck is ours, so no
  // synchroniser is needed on the returning pair
  logic              rd_valid_reg;
  logic [2*DQ_W-1:0] rd_data_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end
    else
    begin
      rd_valid_reg <= tick && link.dq_oe; // [RQ3] [RQ7]
      if (tick && link.dq_oe)
        rd_data_reg <= link.dq; // [RQ4]
    end
  end

  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o  = rd_data_reg;

endmodule

// ===== ddr_rd_monitor.sv
/*
  Checker for the read-burst link: data window, strobe shape, bus
  release and command spacing, all judged on ck.
  Assumes it sits beside the link interface that joins both ends.
*/
module ddr_rd_monitor #(
  parameter int T_RTP_NS = ddr_rd_pkg::T_RTP_NS_DEF
) (
  input wire logic                          resetn_i,
  input wire logic                          ck,
  input wire ddr_rd_pkg::cmd_t              cmd,
  input wire logic [ddr_rd_pkg::BA_W-1:0]   ba,
  input wire logic [ddr_rd_pkg::ADDR_W-1:0] addr,
  input wire logic [2*ddr_rd_pkg::DQ_W-1:0] dq,
  input wire logic                          dq_oe,
  input wire logic [1:0]                    dqs,
  input wire logic [1:0]                    dqs_n,
  input wire logic                          dqs_oe
);
  import ddr_rd_pkg::*;

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  localparam int RTP_CK  = (T_RTP_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int RTP_EFF = (RTP_CK > RTP_MIN_CK) ? RTP_CK : RTP_MIN_CK;

  logic [LAT_W-1:0] cl_q;
  logic [LAT_W-1:0] al_q;
  logic             bl8_q;
  logic [31:0]      dslot;
  logic [31:0]      pslot;
  logic [CNT_W-1:0] since_rd;
  logic [BA_W-1:0]  rd_ba;
  logic [4:0]       rl;
  logic [4:0]       bl2;

  assign rl  = 5'(cl_q) + 5'(al_q);
  assign bl2 = bl8_q ? 5'h4 : 5'h2;

  always_ff @(posedge ck or negedge resetn_i)
    if (!resetn_i)
    begin
      cl_q  <= CL_RST;
      al_q  <= AL_RST;
      bl8_q <= BL8_RST;
    end
    else if (cmd == CMD_MODE)
    begin
      cl_q  <= addr[MODE_CL_LSB +: LAT_W];
      al_q  <= addr[MODE_AL_LSB +: LAT_W];
      bl8_q <= addr[MODE_BL8_BIT];
    end

  // Slot maps: bit 0 is the ck cycle now being sampled
  always_ff @(posedge ck or negedge resetn_i)
    if (!resetn_i)
    begin
      dslot <= '0;
      pslot <= '0;
    end
    else
    begin
      dslot <= (dslot >> 1) | ((cmd == CMD_READ) ? (((32'h0000_0001 << bl2) - 1) << rl) : '0);
      pslot <= (pslot >> 1) | ((cmd == CMD_READ) ? (32'h0000_0001 << (rl - 5'h1)) : '0);
    end

  // Saturating, so the first read after reset never looks close
  always_ff @(posedge ck or negedge resetn_i)
    if (!resetn_i)
    begin
      since_rd <= '1;
      rd_ba    <= '0;
    end
    else if (cmd == CMD_READ)
    begin
      since_rd <= 5'h1;
      rd_ba    <= ba;
    end
    else if (since_rd != '1)
      since_rd <= since_rd + 5'h1;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ck);
  endclocking
  default disable iff (!resetn_i);

  sequence s_last_elem;
    dq_oe && dqs_oe && dqs[0] == 1'b0;
  endsequence

  sequence s_released;
    !dq_oe;
  endsequence

  sequence s_trunc_pair;
    (cmd == CMD_READ && bl8_q && !addr[AP_BIT]) ##2 (cmd == CMD_READ);
  endsequence

  AST_DATA_WIN: assert property (dslot[0] |-> dq_oe && dqs_oe && dqs == DQS_DATA)
    else $error("data slot without driven data");
  AST_PREAMBLE: assert property (pslot[0] && !dslot[0] |-> dqs_oe && !dq_oe && dqs == DQS_PRE)
    else $error("strobe preamble missing");
  AST_STROBE_PAIR: assert property (dqs_oe |-> dqs_n == ~dqs)
    else $error("strobe halves not complementary");
  AST_LAST_ELEM: assert property (dslot[0] && !dslot[1] |-> s_last_elem ##1 s_released)
    else $error("bad postamble or late release");
  AST_RELEASE: assert property (!dslot[0] |-> !dq_oe)
    else $error("data driven outside a burst");
  AST_TRUNC_GAP: assert property (cmd == CMD_READ && since_rd < bl2 |-> since_rd == 5'(TRUNC_GAP_CK) && bl8_q)
    else $error("read cuts a burst illegally");
  AST_TRUNC_IDLE: assert property (s_trunc_pair |-> $past(cmd) == CMD_NOP)
    else $error("command inside a truncation gap");
  AST_WR_GAP: assert property (cmd == CMD_WRITE |-> since_rd >= bl2 + 5'(WR_EXTRA_CK))
    else $error("write before read data drained");
  AST_PRE_GAP: assert property (cmd == CMD_PRE && (addr[AP_BIT] || ba == rd_ba)
    |-> since_rd >= 5'(al_q) + bl2 - 5'h2 + 5'(RTP_EFF))
    else $error("precharge too close to read");
endmodule

// ===== ddr2_read_burst_timing_tb.sv
/*
  Self-checking bench: controller and device joined by the link,
  checker beside it; read data checked on the wire and at capture.
  Assumes ck is divided from clk_i inside the controller.
*/
module ddr2_read_burst_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_rd_pkg::*;

  logic              clk_i;
  logic              resetn_i;
  logic              req_valid_i;
  logic              req_ready_o;
  cmd_t              req_cmd_i;
  logic [BA_W-1:0]   req_ba_i;
  logic [ADDR_W-1:0] req_addr_i;
  logic              req_trunc_i;
  logic              rd_valid_o;
  logic [15:0]       rd_data_o;
  logic [NBANK-1:0]  ctl_open;
  logic [NBANK-1:0]  dev_open;
  logic [15:0]       q_wire[$];
  logic [15:0]       q_cap[$];
  int                err_total;
  int                checks_done;
  logic [LAT_W-1:0]  cl;
  logic [LAT_W-1:0]  al;
  logic              bl8;
  logic [6:0]        mode_tab[4] = '{7'h03, 7'h4c, 7'h52, 7'h1d};

  ddr_link_if link_if ();

  ddr_rd_ctrl #(.T_RTP_NS(T_RTP_NS_DEF), .T_RP_NS(T_RP_NS_DEF)) i_ddr_rd_ctrl (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link_if), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_ba_i(req_ba_i),
    .req_addr_i(req_addr_i), .req_trunc_i(req_trunc_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .bank_open_o(ctl_open));

  ddr_rd_device i_ddr_rd_device (.link(link_if), .resetn_i(resetn_i), .bank_open_o(dev_open));

  ddr_rd_monitor #(.T_RTP_NS(T_RTP_NS_DEF)) i_ddr_rd_monitor (
    .resetn_i(resetn_i), .ck(link_if.ck), .cmd(link_if.cmd), .ba(link_if.ba),
    .addr(link_if.addr), .dq(link_if.dq), .dq_oe(link_if.dq_oe), .dqs(link_if.dqs),
    .dqs_n(link_if.dqs_n), .dqs_oe(link_if.dqs_oe));

  initial clk_i = 1'b0;
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [15:0] pop_q(input bit cap);
    if (cap)
      return (q_cap.size() > 0) ? q_cap.pop_front() : 16'hxxxx;
    return (q_wire.size() > 0) ? q_wire.pop_front() : 16'hxxxx;
  endfunction

  function automatic elem_t elem(input logic [COL_W-1:0] col, input logic [BA_W-1:0] b,
                                 input int n);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] c;
    m = bl8 ? 10'h007 : 10'h003;
    c = (col & ~m) | ((col + COL_W'(n)) & m);
    return {c[4:0], b};
  endfunction

  // Refused requests are held a while, then withdrawn
  task automatic issue(input cmd_t c, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a,
                       input logic t, input bit refuse);
    int n;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_cmd_i   = c;
    req_ba_i    = b;
    req_addr_i  = a;
    req_trunc_i = t;
    // Let ready settle on the new request before it is judged
    #1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < (refuse ? 24 : 600))
    begin
      @(negedge clk_i);
      n++;
    end
    if (refuse)
      cmp_val(16'h0000, {15'h0000, req_ready_o});
    else if (n == 600)
      cmp_val(16'h0001, 16'h0000);
    else
      @(posedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask

  // Truncation drops the last two pairs of the burst being cut
  task automatic rd(input logic [BA_W-1:0] b, input logic ap, input logic t);
    logic [COL_W-1:0] col;
    col = COL_W'($urandom());
    issue(CMD_READ, b, {3'h0, ap, col}, t, 1'b0);
    if (t)
      repeat (2)
      begin
        void'(q_wire.pop_back());
        void'(q_cap.pop_back());
      end
    for (int k = 0; k < (bl8 ? 4 : 2); k++)
    begin
      q_wire.push_back({elem(col, b, 2 * k), elem(col, b, 2 * k + 1)});
      q_cap.push_back({elem(col, b, 2 * k), elem(col, b, 2 * k + 1)});
    end
  endtask

  // ----------------------------------------------------------------
  // Watchers
  // ----------------------------------------------------------------
  always @(negedge link_if.ck)
    if (link_if.dq_oe === 1'b1)
      cmp_val(pop_q(1'b0), link_if.dq);

  always @(negedge clk_i)
    if (rd_valid_o === 1'b1)
      cmp_val(pop_q(1'b1), rd_data_o);

  // Whole run is a few hundred clocks; this is ample margin
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    end_sim;
  end

  initial
  begin
    logic [BA_W-1:0] b;
    err_total   = 0;
    checks_done = 0;
    resetn_i    = 1'b0;
    req_valid_i = 1'b0;
    req_cmd_i   = CMD_NOP;
    req_ba_i    = '0;
    req_addr_i  = '0;
    req_trunc_i = 1'b0;
    {bl8, al, cl} = {BL8_RST, AL_RST, CL_RST};
    void'($urandom(32'h124e9128));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    issue(CMD_READ, 3'h0, '0, 1'b0, 1'b1);
    foreach (mode_tab[i])
    begin
      issue(CMD_MODE, '0, {7'h00, mode_tab[i]}, 1'b0, 1'b0);
      {bl8, al, cl} = mode_tab[i];
      b = BA_W'($urandom_range(NBANK - 1));
      issue(CMD_ACT, b, ADDR_W'($urandom()), 1'b0, 1'b0);
      rd(b, 1'b0, 1'b0);
      rd(b, 1'b0, 1'b0);
      if (bl8)
      begin
        rd(b, 1'b0, 1'b0);
        rd(b, 1'b0, 1'b1);
      end
      issue(CMD_WRITE, b, '0, 1'b0, 1'b0);
      cmp_val(16'(8'h01 << b), {8'h00, dev_open});
      cmp_val(16'(8'h01 << b), {8'h00, ctl_open});
      issue(CMD_PRE, b, '0, 1'b0, 1'b0);
      issue(CMD_READ, b, '0, 1'b0, 1'b1);
      issue(CMD_ACT, b, '0, 1'b0, 1'b0);
      rd(b, 1'b1, 1'b0);
      repeat (2 * (int'(al) + int'(cl) + 6)) @(negedge clk_i);
      cmp_val(16'h0000, {8'h00, dev_open});
      cmp_val(16'h0000, {8'h00, ctl_open});
    end
    repeat (40) @(negedge clk_i);
    cmp_val(16'h0000, 16'(q_wire.size() + q_cap.size()));
    end_sim;
  end
endmodule
